// ===== hdl/gpio_wake_regs.vh
// Register map, field positions and reset values of the wake-capable pin port.
// Assumes word-aligned Avalon-MM access, data in the low byte of each word.
`ifndef GPIO_WAKE_REGS_VH
`define GPIO_WAKE_REGS_VH
`define NPINS           16
`define ADDR_W          8
// Register indices; byte address is four times the index
`define IDX_SER2_DATA   8'h4F
`define IDX_LED_DATA    8'h50
`define IDX_CFG_BASE    8'h00
`define IDX_WAKE_STS    8'h10
`define IDX_WAKE_EN     8'h12
`define IDX_GLB_EN      8'h14
`define IDX_MISC_STS    8'h15
`define IDX_ALT_SEL     8'h16
`define IDX_WAKE_OUT    8'h17
`define CFG_DIR         0
`define CFG_POL         1
`define CFG_ALT         2
`define CFG_OD          7
`define CFG_RST         8'h01
`define LED_PINS        2
`define LED_FIRST       8
`define EE_MASK         16'h0300
`endif

// ===== hdl/pin_sync.v
// Two-stage synchroniser for the pin inputs.
// Assumes pin levels are asynchronous to mclk.
module pin_sync #(
    parameter W = 16
) (
    input  wire         mclk,
    input  wire         rstn,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta_q;
    always @(posedge mclk) begin
        if (!rstn) begin
            meta_q <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // pin_sync

// ===== hdl/edge_detect.v
// Rising and falling edge detector on synchronised pin levels.
// Assumes inputs are already in the mclk domain.
module edge_detect #(
    parameter W = 16
) (
    input  wire         mclk,
    input  wire         rstn,
    input  wire [W-1:0] lvl,
    output wire [W-1:0] rise,
    output wire [W-1:0] fall
);
    reg [W-1:0] prev_q;
    always @(posedge mclk) begin
        if (!rstn)
            prev_q <= {W{1'b0}};
        else
            prev_q <= lvl;
    end
    assign rise = lvl & ~prev_q;
    assign fall = ~lvl & prev_q;
endmodule // edge_detect

// ===== hdl/gpio_wake_port.v
// Pin port: serial-2 pins 0..7 and LED pins 8..9 with wake event logic.
// Assumes an Avalon-MM master on mclk and pad buffers resolving oe_n.
//
// The implementer's own choice: register access over Avalon-MM.
`include "gpio_wake_regs.vh"
module gpio_wake_port (
    input  wire                mclk,
    input  wire                rstn,
    input  wire [`ADDR_W+1:0]  address,
    input  wire                read,
    input  wire                write,
    input  wire [31:0]         writedata,
    input  wire [3:0]          byteenable,
    output reg  [31:0]         readdata,
    output reg                 waitrequest,
    input  wire [`NPINS-1:0]   pin_in,
    output reg  [`NPINS-1:0]   pin_out,
    output reg  [`NPINS-1:0]   pin_oe_n,
    input  wire [`NPINS-1:0]   alt_out,
    input  wire [`NPINS-1:0]   alt_oe,
    output reg  [`NPINS-1:0]   alt_in,
    output reg                 wake_event
);
    localparam ST_IDLE = 2'b00;
    localparam ST_ACK  = 2'b01;
    localparam ST_DONE = 2'b10;
    localparam [`NPINS-1:0] EE_PINS = `EE_MASK;

    reg  [7:0]          cfg_q [0:`NPINS-1];
    reg  [`NPINS-1:0]   data_q;
    reg  [`NPINS-1:0]   wake_sts_q;
    reg  [`NPINS-1:0]   wake_en_q;
    reg  [`NPINS-1:0]   misc_sts_q;
    reg  [`NPINS-1:0]   alt_sel_q;
    reg                 glb_en_q;
    reg  [1:0]          st_q;
    reg  [31:0]         rdata_d;
    wire [`NPINS-1:0]   lvl;
    wire [`NPINS-1:0]   rise;
    wire [`NPINS-1:0]   fall;
    wire [`NPINS-1:0]   dir_in;
    wire [`NPINS-1:0]   pol;
    wire [`NPINS-1:0]   od;
    wire [`NPINS-1:0]   ee_sel;
    wire [`NPINS-1:0]   wake_set;
    wire [`NPINS-1:0]   misc_set;
    wire [`NPINS-1:0]   adj_lvl;
    wire [`ADDR_W-1:0]  idx;
    wire                wr_go;
    wire                rd_go;
    wire                lane0;
    wire                take;
    wire [`NPINS-1:0]   sts_clr;
    wire [`NPINS-1:0]   misc_clr;
    wire [`NPINS-1:0]   out_val;
    wire [`NPINS-1:0]   alt_val;
    wire [7:0]          ser_wr;
    wire [7:0]          led_wr;
    wire [7:0]          ser_rd;
    wire [7:0]          led_rd;

    assign idx   = address[`ADDR_W+1:2];
    assign lane0 = byteenable[0];
    assign take  = (read || write) && (st_q == ST_IDLE);
    // Writes land at the edge where the master sees waitrequest low
    assign wr_go = write && lane0 && (st_q == ST_ACK);
    assign rd_go = read && (st_q == ST_IDLE);

    // Matches either word index of a 16-bit register: index base or base plus one
    function hit;
        input [`ADDR_W-1:0] a;
        input [`ADDR_W-1:0] b;
        begin
            hit = (a == b) || (a == b + 8'h01);
        end
    endfunction

    pin_sync #(.W(`NPINS)) u_sync (
        .mclk (mclk),
        .rstn (rstn),
        .din  (pin_in),
        .dout (lvl)
    );

    edge_detect #(.W(`NPINS)) u_edge (
        .mclk (mclk),
        .rstn (rstn),
        .lvl  (lvl),
        .rise (rise),
        .fall (fall)
    );

    genvar g;
    generate
        for (g = 0; g < `NPINS; g = g + 1) begin : g_pin
            assign dir_in[g]  = cfg_q[g][`CFG_DIR];
            assign pol[g]     = cfg_q[g][`CFG_POL];
            assign od[g]      = cfg_q[g][`CFG_OD];
            assign ee_sel[g]  = alt_sel_q[g] & EE_PINS[g];
            assign adj_lvl[g] = lvl[g] ^ pol[g];
            assign out_val[g] = data_q[g] ^ pol[g];
            assign alt_val[g] = alt_out[g] ^ pol[g];
            // Every port pin is wake-capable here
            // Edge chosen by polarity; outputs excluded unless either-edge
            assign wake_set[g] = ee_sel[g] ? (rise[g] | fall[g]) :
                                 (dir_in[g] & (pol[g] ? fall[g] : rise[g]));
            assign misc_set[g] = ee_sel[g] & (rise[g] | fall[g]);
        end
    endgenerate

    integer ic;
    integer ir;
    integer ip;

    // Places a write byte on the low or high half of a 16-bit register
    function [`NPINS-1:0] wdata16;
        input [`ADDR_W-1:0] off;
        begin
            wdata16 = off[0] ? {writedata[7:0], 8'h00} : {8'h00, writedata[7:0]};
        end
    endfunction

    function [`NPINS-1:0] wmask;
        input [`ADDR_W-1:0] off;
        begin
            wmask = off[0] ? 16'hFF00 : 16'h00FF;
        end
    endfunction

    // Written bits pass for outputs, inputs keep their old value
    function [7:0] keep_inputs;
        input [7:0] wd;
        input [7:0] old;
        input [7:0] is_in;
        begin
            keep_inputs = (wd & ~is_in) | (old & is_in);
        end
    endfunction

    // Inputs read the latched level, outputs the last written bit
    function [7:0] pin_view;
        input [7:0] lv;
        input [7:0] dat;
        input [7:0] is_in;
        begin
            pin_view = (lv & is_in) | (dat & ~is_in);
        end
    endfunction

    // Bus handshake: take when idle, answer one cycle, then recover
    always @(posedge mclk) begin
        if (!rstn) begin
            st_q        <= ST_IDLE;
            waitrequest <= 1'b1;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    if (take) begin
                        st_q        <= ST_ACK;
                        waitrequest <= 1'b0;
                    end
                end
                ST_ACK: begin
                    st_q        <= ST_DONE;
                    waitrequest <= 1'b1;
                end
                ST_DONE: begin
                    st_q <= ST_IDLE;
                end
                default: begin
                    st_q        <= ST_IDLE;
                    waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Read data is registered from the read mux: taken at the take edge, held until the next read
    always @(posedge mclk) begin
        if (!rstn) begin
            readdata <= 32'h00000000;
        end else if (rd_go) begin
            readdata <= rdata_d;
        end
    end

    always @(posedge mclk) begin
        if (!rstn) begin
            for (ic = 0; ic < `NPINS; ic = ic + 1)
                cfg_q[ic] <= `CFG_RST;
        end else if (wr_go) begin
            for (ic = 0; ic < `NPINS; ic = ic + 1)
                if (idx == `IDX_CFG_BASE + ic[7:0])
                    cfg_q[ic] <= writedata[7:0];
        end
    end

    assign ser_wr = keep_inputs(writedata[7:0], data_q[7:0], dir_in[7:0]);
    assign led_wr = keep_inputs({6'h00, writedata[1:0]}, {6'h00, data_q[9:8]}, {6'h00, dir_in[9:8]});

    // Only bits of output pins take the written value
    always @(posedge mclk) begin
        if (!rstn) begin
            data_q <= {`NPINS{1'b0}};
        end else if (wr_go) begin
            if (idx == `IDX_SER2_DATA)
                data_q[7:0] <= ser_wr;
            if (idx == `IDX_LED_DATA)
                data_q[9:8] <= led_wr[1:0];
        end
    end

    always @(posedge mclk) begin
        if (!rstn) begin
            wake_en_q <= {`NPINS{1'b0}};
            alt_sel_q <= {`NPINS{1'b0}};
            glb_en_q  <= 1'b0;
        end else if (wr_go) begin
            if (hit(idx, `IDX_WAKE_EN))
                wake_en_q <= (wake_en_q & ~wmask(idx - `IDX_WAKE_EN)) | wdata16(idx - `IDX_WAKE_EN);
            if (idx == `IDX_ALT_SEL)
                alt_sel_q[9:8] <= writedata[1:0];
            if (idx == `IDX_GLB_EN)
                glb_en_q <= writedata[0];
        end
    end

    assign sts_clr  = (wr_go && hit(idx, `IDX_WAKE_STS)) ? wdata16(idx - `IDX_WAKE_STS) : {`NPINS{1'b0}};
    assign misc_clr = (wr_go && idx == `IDX_MISC_STS) ? {6'h00, writedata[1:0], 8'h00} : {`NPINS{1'b0}};

    // Set wins over a write-one clear in the same cycle
    always @(posedge mclk) begin
        if (!rstn) begin
            wake_sts_q <= {`NPINS{1'b0}};
            misc_sts_q <= {`NPINS{1'b0}};
        end else begin
            wake_sts_q <= (wake_sts_q & ~sts_clr) | wake_set;
            misc_sts_q <= (misc_sts_q & ~misc_clr) | misc_set;
        end
    end

    assign ser_rd = pin_view(adj_lvl[7:0], data_q[7:0], dir_in[7:0]);
    assign led_rd = pin_view({6'h00, adj_lvl[9:8]}, {6'h00, data_q[9:8]}, {6'h00, dir_in[9:8]});

    // Read mux; unmapped indices read zero
    always @* begin
        rdata_d = 32'h00000000;
        for (ir = 0; ir < `NPINS; ir = ir + 1)
            if (idx == `IDX_CFG_BASE + ir[7:0])
                rdata_d = {24'h000000, cfg_q[ir]};
        case (idx)
            `IDX_SER2_DATA: begin
                rdata_d = {24'h000000, ser_rd};
            end
            `IDX_LED_DATA: begin
                rdata_d = {24'h000000, led_rd};
            end
            `IDX_WAKE_STS: begin
                rdata_d = {24'h000000, wake_sts_q[7:0]};
            end
            `IDX_WAKE_STS + 8'h01: begin
                rdata_d = {24'h000000, wake_sts_q[15:8]};
            end
            `IDX_WAKE_EN: begin
                rdata_d = {24'h000000, wake_en_q[7:0]};
            end
            `IDX_WAKE_EN + 8'h01: begin
                rdata_d = {24'h000000, wake_en_q[15:8]};
            end
            `IDX_GLB_EN: begin
                rdata_d = {31'h00000000, glb_en_q};
            end
            `IDX_MISC_STS: begin
                rdata_d = {24'h000000, misc_sts_q[15:8]};
            end
            `IDX_ALT_SEL: begin
                rdata_d = {30'h00000000, alt_sel_q[9:8]};
            end
            `IDX_WAKE_OUT: begin
                rdata_d = {31'h00000000, wake_event};
            end
            default: begin
                rdata_d = rdata_d;
            end
        endcase
    end

    // Pad drive: either-edge pins float, other alternates bypass the data bit
    always @(posedge mclk) begin
        if (!rstn) begin
            pin_out  <= {`NPINS{1'b0}};
            pin_oe_n <= {`NPINS{1'b1}};
        end else begin
            for (ip = 0; ip < `NPINS; ip = ip + 1) begin
                if (ee_sel[ip]) begin
                    pin_out[ip]  <= 1'b0;
                    pin_oe_n[ip] <= 1'b1;
                end else if (alt_sel_q[ip]) begin
                    pin_out[ip]  <= alt_val[ip];
                    pin_oe_n[ip] <= ~(alt_oe[ip] & (~od[ip] | ~alt_val[ip]));
                end else begin
                    pin_out[ip]  <= out_val[ip];
                    pin_oe_n[ip] <= dir_in[ip] | (od[ip] & out_val[ip]);
                end
            end
        end
    end

    // Level handed to the alternate function; either-edge pins see the raw level
    always @(posedge mclk) begin
        if (!rstn) begin
            alt_in <= {`NPINS{1'b0}};
        end else begin
            alt_in <= (lvl & ee_sel) | (adj_lvl & alt_sel_q & ~ee_sel);
        end
    end

    always @(posedge mclk) begin
        if (!rstn)
            wake_event <= 1'b0;
        else
            wake_event <= glb_en_q & |(wake_sts_q & wake_en_q);
    end
endmodule // gpio_wake_port

// ===== dv/gpio_wake_chk.sv
// Checker: bus answer timing, reset state, pin 0 drive against a shadow of its config.
// Assumes binding to gpio_wake_port, one mclk domain.
module gpio_wake_chk (
    input wire        mclk,
    input wire        rstn,
    input wire [9:0]  address,
    input wire        read,
    input wire        write,
    input wire [31:0] writedata,
    input wire [3:0]  byteenable,
    input wire [31:0] readdata,
    input wire        waitrequest,
    input wire [15:0] pin_out,
    input wire [15:0] pin_oe_n,
    input wire        wake_event
);
    logic [7:0] c0_q;
    logic       d0_q;
    logic [1:0] cnt_q;
    wire        wr = write && !waitrequest && byteenable[0];
    wire        settled = cnt_q == 2'h3 && waitrequest;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Shadow of pin 0 config and data bit, with age since the last write
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            c0_q  <= 8'h01;
            d0_q  <= 1'b0;
            cnt_q <= 2'h3;
        end else begin
            cnt_q <= wr ? 2'h0 : cnt_q + {1'b0, cnt_q != 2'h3};
            if (wr && address[9:2] == 8'h00) c0_q <= writedata[7:0];
            if (wr && address[9:2] == 8'h4F && !c0_q[0]) d0_q <= writedata[0];
        end
    end
    sequence ack_s; !waitrequest; endsequence
    sequence glb_off_s; wr && address[9:2] == 8'h14 && !writedata[0]; endsequence
    AST_ACK_ONE: assert property (ack_s |=> waitrequest) else $error("ack held too long");
    AST_TAKE: assert property ((read || write) |-> ##[0:4] ack_s) else $error("no answer");
    AST_RST: assert property ($rose(rstn) |-> waitrequest && &pin_oe_n && !wake_event) else $error("reset state");
    AST_IN_FLOAT: assert property (settled && c0_q[0] |-> pin_oe_n[0]) else $error("input pin driven");
    AST_OUT_PP: assert property (settled && !c0_q[0] && !c0_q[7] |-> !pin_oe_n[0] && pin_out[0] == (d0_q ^ c0_q[1]))
        else $error("push-pull drive");
    AST_OUT_OD: assert property (settled && !c0_q[0] && c0_q[7] |-> pin_oe_n[0] == (d0_q ^ c0_q[1]))
        else $error("open-drain drive");
    AST_WAKE_OFF: assert property (glb_off_s |-> ##2 !wake_event) else $error("wake without global enable");
    AST_BYTE: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0) else $error("wide read");
endmodule // gpio_wake_chk
bind gpio_wake_port gpio_wake_chk chk_u (.mclk, .rstn, .address, .read, .write, .writedata, .byteenable,
    .readdata, .waitrequest, .pin_out, .pin_oe_n, .wake_event);

// ===== dv/pin_board.sv
// Board side of the pins: the port's drive wins, else the board's level.
// Assumes drive holds the level the board wants on released pins.
module pin_board (
    input  wire  [15:0] drive,
    input  wire  [15:0] pin_out,
    input  wire  [15:0] pin_oe_n,
    output logic [15:0] pin_in
);
    always_comb
        for (int i = 0; i < 16; i++) pin_in[i] = pin_oe_n[i] ? drive[i] : pin_out[i];
endmodule // pin_board

// ===== dv/testbench.sv
// Testbench: config and data access, pin levels, wake and edge status.
// Assumes the design header on the include path and the board model.
`include "gpio_wake_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0;
    logic [9:0]  address = 10'h0;
    logic [31:0] writedata = 32'h0, readdata;
    logic        waitrequest, wake_event;
    logic [15:0] pin_in, pin_out, pin_oe_n, alt_in, drv = 16'h0;
    logic [7:0]  cfg_m [16];
    logic        dat_m [16];
    int          total_checks = 0, miscompares = 0, cyc = 0;
    gpio_wake_port dut_u (.mclk, .rstn, .address, .read, .write, .writedata, .byteenable(4'hF), .readdata,
        .waitrequest, .pin_in, .pin_out, .pin_oe_n, .alt_out(16'h0), .alt_oe(16'h0), .alt_in, .wake_event);
    pin_board board_u (.drive(drv), .pin_out, .pin_oe_n, .pin_in);
    initial forever #5 mclk = ~mclk;
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge mclk);
        address <= {idx, 2'h0};
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, wd};
        do @(posedge mclk); while (waitrequest !== 1'b0);
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_sim();
        end
    end
    function automatic logic exp_lvl(input int p);
        logic lv;
        lv = dat_m[p] ^ cfg_m[p][`CFG_POL];
        if (cfg_m[p][`CFG_DIR])
            return drv[p];
        return cfg_m[p][`CFG_OD] ? (lv & drv[p]) : lv;
    endfunction
    function automatic logic [7:0] exp_data(input int b);
        logic [7:0] e;
        for (int i = 0; i < 8; i++)
            e[i] = cfg_m[b+i][`CFG_DIR] ? drv[b+i] ^ cfg_m[b+i][`CFG_POL] : dat_m[b+i];
        return e;
    endfunction
    // Pin 0 is set up, edged from f to t, and its wake status compared
    task automatic edge_case(input logic [7:0] c, input logic f, input logic t, input logic e);
        logic [7:0] rd;
        drv[0] <= f;
        bus(1'b1, 8'h00, c, rd);
        bus(1'b1, `IDX_SER2_DATA, 8'h01, rd);
        repeat (6) @(posedge mclk);
        bus(1'b1, `IDX_WAKE_STS, 8'hFF, rd);
        drv[0] <= t;
        repeat (6) @(posedge mclk);
        bus(1'b0, `IDX_WAKE_STS, 8'h00, rd);
        chk("wake status", rd & 8'h01, {7'h0, e});
        chk("wake event", {7'h0, wake_event}, {7'h0, e});
    endtask
    initial begin
        logic [7:0] rd, c, wd, m;
        int         p, b;
        void'($urandom(32'h4E3F));
        cfg_m = '{default: `CFG_RST};
        dat_m = '{default: 1'b0};
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            bus(1'b0, 8'(i), 8'h00, rd);
            chk("cfg reset", rd, `CFG_RST);
        end
        bus(1'b0, 8'h30, 8'h00, rd);
        chk("unmapped", rd, 8'h00);
        repeat (30) begin
            p = $urandom_range(9);
            b = p < 8 ? 0 : 8;
            m = p < 8 ? 8'hFF : 8'h03;
            c = $urandom & 8'h83;
            wd = $urandom;
            drv <= $urandom;
            cfg_m[p] = c;
            bus(1'b1, 8'(p), c, rd);
            bus(1'b0, 8'(p), 8'h00, rd);
            chk("cfg", rd, c);
            bus(1'b1, b ? `IDX_LED_DATA : `IDX_SER2_DATA, wd, rd);
            for (int i = 0; i < 8; i++)
                if (!cfg_m[b+i][`CFG_DIR]) dat_m[b+i] = wd[i];
            repeat (4) @(posedge mclk);
            chk("pin level", {7'h0, pin_in[p]}, {7'h0, exp_lvl(p)});
            bus(1'b0, b ? `IDX_LED_DATA : `IDX_SER2_DATA, 8'h00, rd);
            chk("data", rd & m, exp_data(b) & m);
        end
        bus(1'b1, `IDX_WAKE_EN, 8'h01, rd);
        bus(1'b1, `IDX_GLB_EN, 8'h01, rd);
        edge_case(8'h01, 1'b0, 1'b1, 1'b1);
        edge_case(8'h01, 1'b1, 1'b0, 1'b0);
        edge_case(8'h80, 1'b0, 1'b1, 1'b0);
        edge_case(8'h03, 1'b1, 1'b0, 1'b1);
        bus(1'b1, `IDX_WAKE_EN, 8'h00, rd);
        repeat (3) @(posedge mclk);
        chk("wake masked", {7'h0, wake_event}, 8'h00);
        bus(1'b1, `IDX_WAKE_STS, 8'h00, rd);
        bus(1'b0, `IDX_WAKE_STS, 8'h00, rd);
        chk("status kept", rd & 8'h01, 8'h01);
        bus(1'b1, `IDX_WAKE_STS, 8'h01, rd);
        bus(1'b0, `IDX_WAKE_STS, 8'h00, rd);
        chk("status cleared", rd & 8'h01, 8'h00);
        bus(1'b1, `IDX_GLB_EN, 8'h00, rd);
        bus(1'b1, `IDX_ALT_SEL, 8'h01, rd);
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, `IDX_MISC_STS, 8'h03, rd);
            drv[8] <= ~drv[8];
            repeat (6) @(posedge mclk);
            bus(1'b0, `IDX_MISC_STS, 8'h00, rd);
            chk("edge status", rd & 8'h01, 8'h01);
            chk("alt level", {7'h0, alt_in[8]}, {7'h0, drv[8]});
        end
        end_sim();
    end
endmodule // testbench
